// >>> rtl/hpsf_map.svh
// Bit positions and reset values of the host port status flags.
`ifndef HPSF_MAP_SVH
`define HPSF_MAP_SVH

// Reset value of every status register.
`define HPSF_STR_RESET 8'h00

// Channel 2 status layout.
`define HPSF_CD_BIT 3
`define HPSF_IN2_FULL_BIT 1
`define HPSF_OUT2_FULL_BIT 0
`define HPSF_USER_HI_MSB 7
`define HPSF_USER_HI_LSB 4
`define HPSF_USER_LO_BIT 2

// Channel 3 bidirectional layout.
`define HPSF_BI_IN_FULL_BIT 7
`define HPSF_BI_OUT_FULL_BIT 6
`define HPSF_HOST_MODE_BIT 5
`define HPSF_SLV_MODE_BIT 4

// Value a flag takes when it is cleared.
`define HPSF_FLAG_CLEAR 1'b0

// Value read back for a status byte that this block does not present.
`define HPSF_NO_STATUS 8'h00

// Width of a status register.
`define HPSF_STR_W 8

`endif

// >>> rtl/hpsf_pkg.sv
// Types shared by the host port status flag logic.
`default_nettype none
package hpsf_pkg;

    // Which status register a host read cycle addresses.
    typedef enum logic {
        HPSF_SEL_CH2,
        HPSF_SEL_CH3
    } hpsf_str_sel_t;

    // A status byte.
    typedef logic [7:0] hpsf_byte_t;

endpackage

`default_nettype wire

// >>> rtl/hpsf_flag_cell.sv
// One hardware status flag with a set event and a clear event.
`timescale 1ns/100ps
`default_nettype none

// The flag cell needs the clear value even when compiled on its own.
`include "hpsf_map.svh"

module hpsf_flag_cell
    import hpsf_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output var logic flag_o
);

    // Stored flag and its next value.
    logic flag_reg;
    logic flag_next;

    ////////////////////////////////////////////////////////////////////////
    // Next value: a set in the same cycle as a clear wins, so that an
    // event that lands on a clear is never lost.
    always_comb
    begin
        flag_next = flag_reg;
        if (set_i)
        begin
            flag_next = 1'b1;
        end
        else if (clr_i)
        begin
            flag_next = `HPSF_FLAG_CLEAR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register, cleared by the synchronous reset.
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            flag_reg <= `HPSF_FLAG_CLEAR;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    // The flag comes straight from its flip-flop.
    assign flag_o = flag_reg;

endmodule

`default_nettype wire

// >>> rtl/hpsf_status_regs.sv
// Status flags of host channel 2 and the channel 3 bidirectional bank.
//
// Function
// - Channel 2 bits 7-4, 2: slave user bits.
// - Host data write latches address bit 2.
// - Host data write sets channel 2 input-full.
// - Slave data read clears channel 2 input-full.
// - Slave output write sets channel 2 output-full.
// - Host output read or slave zero clears it.
// - Clearable flags: slave writes only zero.
// - Bidirectional layout when enabled or unselected.
// - Host last-register write sets bidir input-full.
// - Slave last-register read clears bidir input-full.
// - Slave last-register write sets bidir output-full.
// - Host last read or slave zero clears it.
// - Host first write sets host mode, slave idle.
// - Slave last-register read clears host mode.
// - Slave first write sets slave mode, host idle.
// - Simultaneous first writes: host wins.
// - Host last read, slave zero clear slave mode.
// - Host read returns selected status value.
// - All status registers reset to zero.
`timescale 1ns/100ps
`default_nettype none

`include "hpsf_map.svh"

module hpsf_status_regs
    import hpsf_pkg::*;
(
    // System clock, 125 MHz.
    input wire logic sys_clk_i,
    // Synchronous reset, active high.
    input wire logic rst_i,

    // Host side: decoded I/O cycle strobes, one cycle each.
    input wire logic host_idr2_wr_i,
    input wire logic host_addr2_i,
    input wire logic host_odr2_rd_i,
    input wire logic host_last_wr_i,
    input wire logic host_last_rd_i,
    input wire logic host_first_wr_i,
    input wire logic host_str_rd_i,
    input wire logic host_str_sel_i,
    input wire logic host_str_wr_i,
    output var logic [7:0] host_rdata_o,
    output var logic host_rvalid_o,

    // Slave processor side: decoded access strobes, one cycle each.
    input wire logic slv_stat2_wr_i,
    input wire logic slv_stat3_wr_i,
    input wire logic [7:0] slv_wdata_i,
    input wire logic slv_idr2_rd_i,
    input wire logic slv_odr2_wr_i,
    input wire logic slv_last_rd_i,
    input wire logic slv_last_wr_i,
    input wire logic slv_first_wr_i,
    output var logic [7:0] slv_stat2_o,
    output var logic [7:0] slv_stat3_o,

    // Mode controls from the channel 3 configuration.
    input wire logic bidir_mode_enable_i,
    input wire logic ch3_status_select_i,

    // Interrupt sources and layout indication towards the slave.
    output var logic ch2_input_full_o,
    output var logic bidir_input_full_o,
    output var logic bidir_layout_o
);

    ////////////////////////////////////////////////////////////////////////
    // Helper: a slave write that carries a zero in the given bit position
    // clears a clearable flag; a one in that position does nothing.
    function automatic logic zero_clears(input logic wr,
                                         input logic [7:0] data,
                                         input int unsigned pos);
        logic bit_val;
        bit_val = data[pos[2:0]];
        return wr && (bit_val == 1'b0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Slave user bits 7-4 of channel 2.
    logic [3:0] user_hi_reg;
    logic [3:0] user_hi_next;
    // Slave user bit 2 of channel 2.
    logic user_lo_reg;
    logic user_lo_next;
    // Command or data indication of channel 2.
    logic cmd_data_reg;
    logic cmd_data_next;

    // Host read data and its valid pulse.
    logic [7:0] host_rdata_reg;
    logic [7:0] host_rdata_next;
    logic host_rvalid_reg;
    logic host_rvalid_next;

    // Hardware flags, each held in a flag cell.
    logic in2_full_flag;
    logic out2_full_flag;
    logic bi_in_full_flag;
    logic bi_out_full_flag;
    logic host_mode_flag;
    logic slv_mode_flag;

    // Set and clear events for the flag cells.
    logic in2_full_set;
    logic in2_full_clr;
    logic out2_full_set;
    logic out2_full_clr;
    logic bi_in_full_set;
    logic bi_in_full_clr;
    logic bi_out_full_set;
    logic bi_out_full_clr;
    logic host_mode_set;
    logic host_mode_clr;
    logic slv_mode_set;
    logic slv_mode_clr;

    // Bidirectional layout is the one shown in channel 3.
    logic bidir_layout;
    // Slave writes to channel 3 reach this layout only while it is shown.
    logic slv_stat3_wr_bidir;
    // Assembled status bytes.
    hpsf_byte_t ch2_status;
    hpsf_byte_t ch3_status;

    ////////////////////////////////////////////////////////////////////////
    // Layout selection of channel 3.
    always_comb
    begin
        bidir_layout = bidir_mode_enable_i || !ch3_status_select_i;
        slv_stat3_wr_bidir = slv_stat3_wr_i && bidir_layout;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag events. The flag cells let a set win over a clear in the same
    // cycle, so a host event is never lost under a slave clear.
    always_comb
    begin
        // Channel 2 input-full: host data write sets, slave read clears.
        in2_full_set = host_idr2_wr_i;
        in2_full_clr = slv_idr2_rd_i;
        // Channel 2 output-full.
        out2_full_set = slv_odr2_wr_i;
        out2_full_clr = host_odr2_rd_i ||
                        zero_clears(slv_stat2_wr_i, slv_wdata_i,
                                    `HPSF_OUT2_FULL_BIT);
        // Bidirectional input-full.
        bi_in_full_set = host_last_wr_i;
        bi_in_full_clr = slv_last_rd_i;
        // Bidirectional output-full.
        bi_out_full_set = slv_last_wr_i;
        bi_out_full_clr = host_last_rd_i ||
                          zero_clears(slv_stat3_wr_bidir, slv_wdata_i,
                                      `HPSF_BI_OUT_FULL_BIT);
        // Host write mode: only claimed while the slave has not claimed.
        host_mode_set = host_first_wr_i && !slv_mode_flag;
        host_mode_clr = slv_last_rd_i;
        // Slave write mode: refused while the host holds the mode or
        // writes the first register in this very cycle.
        slv_mode_set = slv_first_wr_i && !host_mode_flag &&
                       !host_first_wr_i;
        slv_mode_clr = host_last_rd_i ||
                       zero_clears(slv_stat3_wr_bidir, slv_wdata_i,
                                   `HPSF_SLV_MODE_BIT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag cells.

    // Channel 2 input-full.
    hpsf_flag_cell u_in2_full (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(in2_full_set),
        .clr_i(in2_full_clr),
        .flag_o(in2_full_flag)
    );

    // Channel 2 output-full.
    hpsf_flag_cell u_out2_full (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(out2_full_set),
        .clr_i(out2_full_clr),
        .flag_o(out2_full_flag)
    );

    // Bidirectional input-full.
    hpsf_flag_cell u_bi_in_full (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(bi_in_full_set),
        .clr_i(bi_in_full_clr),
        .flag_o(bi_in_full_flag)
    );

    // Bidirectional output-full.
    hpsf_flag_cell u_bi_out_full (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(bi_out_full_set),
        .clr_i(bi_out_full_clr),
        .flag_o(bi_out_full_flag)
    );

    // Host write-mode flag.
    hpsf_flag_cell u_host_mode (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(host_mode_set),
        .clr_i(host_mode_clr),
        .flag_o(host_mode_flag)
    );

    // Slave write-mode flag.
    hpsf_flag_cell u_slv_mode (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(slv_mode_set),
        .clr_i(slv_mode_clr),
        .flag_o(slv_mode_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next values of channel 2 user bits and command or data bit.
    always_comb
    begin
        user_hi_next = user_hi_reg;
        user_lo_next = user_lo_reg;
        cmd_data_next = cmd_data_reg;
        // Only the slave writes the user bits; the host cannot.
        if (slv_stat2_wr_i)
        begin
            user_hi_next = slv_wdata_i[`HPSF_USER_HI_MSB:
                                       `HPSF_USER_HI_LSB];
            user_lo_next = slv_wdata_i[`HPSF_USER_LO_BIT];
        end
        // Each host data write records whether it was a command.
        if (host_idr2_wr_i)
        begin
            cmd_data_next = host_addr2_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status bytes as seen by both sides.
    always_comb
    begin
        ch2_status = `HPSF_STR_RESET;
        ch2_status[`HPSF_USER_HI_MSB:`HPSF_USER_HI_LSB] = user_hi_reg;
        ch2_status[`HPSF_CD_BIT] = cmd_data_reg;
        ch2_status[`HPSF_USER_LO_BIT] = user_lo_reg;
        ch2_status[`HPSF_IN2_FULL_BIT] = in2_full_flag;
        ch2_status[`HPSF_OUT2_FULL_BIT] = out2_full_flag;
        // The other channel 3 layout lives outside this block, so this
        // byte reads as zero while that layout is selected.
        ch3_status = `HPSF_NO_STATUS;
        if (bidir_layout)
        begin
            ch3_status[`HPSF_BI_IN_FULL_BIT] = bi_in_full_flag;
            ch3_status[`HPSF_BI_OUT_FULL_BIT] = bi_out_full_flag;
            ch3_status[`HPSF_HOST_MODE_BIT] = host_mode_flag;
            ch3_status[`HPSF_SLV_MODE_BIT] = slv_mode_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read path. The byte is captured at the edge that takes the
    // read, so the host sees the value from before any same-cycle update.
    // Host status writes never reach any state here.
    always_comb
    begin
        host_rdata_next = host_rdata_reg;
        host_rvalid_next = host_str_rd_i;
        if (host_str_rd_i)
        begin
            if (host_str_sel_i == HPSF_SEL_CH3)
            begin
                host_rdata_next = ch3_status;
            end
            else
            begin
                host_rdata_next = ch2_status;
            end
        end
        // host_str_wr_i is deliberately left without effect.
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers of the user bits, the command flag and the read path.
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            user_hi_reg <= '0;
            user_lo_reg <= `HPSF_FLAG_CLEAR;
            cmd_data_reg <= `HPSF_FLAG_CLEAR;
            host_rdata_reg <= `HPSF_STR_RESET;
            host_rvalid_reg <= 1'b0;
        end
        else
        begin
            user_hi_reg <= user_hi_next;
            user_lo_reg <= user_lo_next;
            cmd_data_reg <= cmd_data_next;
            host_rdata_reg <= host_rdata_next;
            host_rvalid_reg <= host_rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. Channel 2 status is built from flip-flops only; channel 3 is also gated by the layout inputs.
    assign host_rdata_o = host_rdata_reg;
    assign host_rvalid_o = host_rvalid_reg;
    assign slv_stat2_o = ch2_status;
    assign slv_stat3_o = ch3_status;
    // Input-full flags double as slave interrupt sources.
    assign ch2_input_full_o = in2_full_flag;
    assign bidir_input_full_o = bi_in_full_flag;
    assign bidir_layout_o = bidir_layout;

endmodule

`default_nettype wire

// >>> tb/hpsf_status_chk.sv
// Concurrent checks on the ports of the host port status flag block.
`timescale 1ns/100ps
`default_nettype none

module hpsf_status_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic host_idr2_wr_i,
    input wire logic host_addr2_i,
    input wire logic host_odr2_rd_i,
    input wire logic host_last_wr_i,
    input wire logic host_first_wr_i,
    input wire logic host_str_rd_i,
    input wire logic host_str_sel_i,
    input wire logic slv_idr2_rd_i,
    input wire logic slv_odr2_wr_i,
    input wire logic slv_last_rd_i,
    input wire logic slv_first_wr_i,
    input wire logic bidir_mode_enable_i,
    input wire logic ch3_status_select_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic host_rvalid_o,
    input wire logic [7:0] slv_stat2_o,
    input wire logic [7:0] slv_stat3_o,
    input wire logic ch2_input_full_o,
    input wire logic bidir_input_full_o,
    input wire logic bidir_layout_o
);

    // All checks share the one clock and its synchronous reset.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    a_in2_full_set:
        assert property (host_idr2_wr_i
                         |=> slv_stat2_o[1] && ch2_input_full_o)
        else $error("ch2 input-full not set");
    a_cmd_latch:
        assert property (host_idr2_wr_i
                         |=> slv_stat2_o[3] == $past(host_addr2_i))
        else $error("command flag does not follow address bit");
    a_in2_full_clear:
        assert property (slv_idr2_rd_i && !host_idr2_wr_i
                         |=> !ch2_input_full_o)
        else $error("ch2 input-full not cleared");
    a_out2_full_set:
        assert property (slv_odr2_wr_i |=> slv_stat2_o[0])
        else $error("ch2 output-full not set");
    a_out2_full_clear:
        assert property (host_odr2_rd_i && !slv_odr2_wr_i
                         |=> !slv_stat2_o[0])
        else $error("ch2 output-full not cleared");
    a_layout_sel:
        assert property (bidir_layout_o == (bidir_mode_enable_i
                                            || !ch3_status_select_i))
        else $error("layout select wrong");
    a_bi_in_set:
        assert property (host_last_wr_i |=> bidir_input_full_o)
        else $error("bidir input-full not set");
    a_host_mode_clear:
        assert property (slv_last_rd_i && !host_first_wr_i ##1 bidir_layout_o
                         |-> !slv_stat3_o[5])
        else $error("host mode flag not cleared");
    // Both sides claim the bank in one cycle: the host must win.
    a_host_wins:
        assert property (host_first_wr_i && slv_first_wr_i && bidir_layout_o
                         && !slv_stat3_o[4] ##1 bidir_layout_o
                         |-> slv_stat3_o[5:4] == 2'b10)
        else $error("simultaneous claim not won by host");
    a_status_read:
        assert property (host_str_rd_i && !host_str_sel_i
                         |=> host_rvalid_o
                         && host_rdata_o == $past(slv_stat2_o))
        else $error("status read returned wrong byte");
    a_rvalid_pulse:
        assert property (!host_str_rd_i |=> !host_rvalid_o)
        else $error("read valid without a read");

endmodule

bind hpsf_status_regs hpsf_status_chk u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .host_idr2_wr_i(host_idr2_wr_i), .host_addr2_i(host_addr2_i),
    .host_odr2_rd_i(host_odr2_rd_i), .host_last_wr_i(host_last_wr_i),
    .host_first_wr_i(host_first_wr_i), .host_str_rd_i(host_str_rd_i),
    .host_str_sel_i(host_str_sel_i), .slv_idr2_rd_i(slv_idr2_rd_i),
    .slv_odr2_wr_i(slv_odr2_wr_i), .slv_last_rd_i(slv_last_rd_i),
    .slv_first_wr_i(slv_first_wr_i),
    .bidir_mode_enable_i(bidir_mode_enable_i),
    .ch3_status_select_i(ch3_status_select_i),
    .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .slv_stat2_o(slv_stat2_o), .slv_stat3_o(slv_stat3_o),
    .ch2_input_full_o(ch2_input_full_o),
    .bidir_input_full_o(bidir_input_full_o),
    .bidir_layout_o(bidir_layout_o)
);

`default_nettype wire

// >>> tb/hpsf_host_model.sv
// Behavioural host that issues decoded I/O cycles towards the flags.
`timescale 1ns/100ps
`default_nettype none

module hpsf_host_model (
    input wire logic sys_clk_i,
    output logic [6:0] strobe_o,
    output logic addr2_o,
    output logic sel_o
);

    // Idle bus at time zero: no cycle in flight.
    initial
    begin
        strobe_o = 7'h00;
        addr2_o = 1'b0;
        sel_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One I/O cycle, held for exactly one clock from a falling edge.
    task automatic io(input logic [6:0] s, input logic a2, input logic sel);
        @(negedge sys_clk_i);
        strobe_o = s;
        addr2_o = a2;
        sel_o = sel;
        @(negedge sys_clk_i);
        strobe_o = 7'h00;
        // Qualifiers are not held after the cycle; flipping them keeps a
        // stale value from passing for a valid one.
        addr2_o = ~a2;
        sel_o = ~sel;
    endtask

endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench of the host port status flags.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb;

    // Host cycle kinds, one strobe bit each.
    localparam logic [6:0] H_IN2 = 7'h40, H_OUT2 = 7'h20, H_LW = 7'h10;
    localparam logic [6:0] H_LR = 7'h08, H_FW = 7'h04, H_SR = 7'h02;
    localparam logic [6:0] H_SW = 7'h01;
    // Slave access kinds, one strobe bit each.
    localparam logic [6:0] S_S2 = 7'h40, S_S3 = 7'h20, S_IR = 7'h10;
    localparam logic [6:0] S_OW = 7'h08, S_LR = 7'h04, S_LW = 7'h02;
    localparam logic [6:0] S_FW = 7'h01;

    logic sys_clk_i, rst_i, a2, hsel, en, csel, rvalid, in2_full, bi_full;
    logic lay;
    logic [6:0] hs, ss;
    logic [7:0] wd, rdata, s2, s3;
    int err_total, checks_done;

    hpsf_host_model u_host (.sys_clk_i(sys_clk_i), .strobe_o(hs),
        .addr2_o(a2), .sel_o(hsel));

    hpsf_status_regs u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .host_idr2_wr_i(hs[6]), .host_addr2_i(a2), .host_odr2_rd_i(hs[5]),
        .host_last_wr_i(hs[4]), .host_last_rd_i(hs[3]),
        .host_first_wr_i(hs[2]), .host_str_rd_i(hs[1]),
        .host_str_sel_i(hsel), .host_str_wr_i(hs[0]),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid),
        .slv_stat2_wr_i(ss[6]), .slv_stat3_wr_i(ss[5]), .slv_wdata_i(wd),
        .slv_idr2_rd_i(ss[4]), .slv_odr2_wr_i(ss[3]), .slv_last_rd_i(ss[2]),
        .slv_last_wr_i(ss[1]), .slv_first_wr_i(ss[0]),
        .slv_stat2_o(s2), .slv_stat3_o(s3),
        .bidir_mode_enable_i(en), .ch3_status_select_i(csel),
        .ch2_input_full_o(in2_full), .bidir_input_full_o(bi_full),
        .bidir_layout_o(lay));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 125 MHz clock.
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // One slave access held for one clock; data is scrambled afterwards.
    task automatic sp(input logic [6:0] s, input logic [7:0] d);
        @(negedge sys_clk_i);
        ss = s;
        wd = d;
        @(negedge sys_clk_i);
        ss = 7'h00;
        wd = ~d;
    endtask

    // Host status read; data and valid are due one clock after the strobe.
    task automatic rd(input logic sel, input logic [7:0] e);
        u_host.io(H_SR, 1'b0, sel);
        `CHK("rdata", e, rdata)
        `CHK("rvalid", 1'b1, rvalid)
        @(negedge sys_clk_i);
        `CHK("rvalid gone", 1'b0, rvalid)
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // A run needs about 90 clocks; this bound only catches a hang.
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_i = 1'b1;
        ss = 7'h00;
        wd = 8'h00;
        en = 1'b1;
        csel = 1'b1;
        err_total = 0;
        checks_done = 0;
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        `CHK("stat2 rst", 8'h00, s2)
        `CHK("stat3 rst", 8'h00, s3)
        sp(S_S2, 8'hff);
        `CHK("user bits", 8'hf4, s2)
        rd(1'b0, 8'hf4);
        u_host.io(H_IN2, 1'b1, 1'b0);
        `CHK("cmd in", 8'hfe, s2)
        `CHK("irq2", 1'b1, in2_full)
        u_host.io(H_SW, 1'b0, 1'b0);
        `CHK("host stat wr", 8'hfe, s2)
        u_host.io(H_IN2, 1'b0, 1'b0);
        `CHK("data in", 8'hf6, s2)
        sp(S_IR, 8'h00);
        `CHK("in2 read", 8'hf4, s2)
        sp(S_OW, 8'h00);
        `CHK("out2 wr", 8'hf5, s2)
        sp(S_S2, 8'h00);
        `CHK("zero wr", 8'h00, s2)
        sp(S_OW, 8'h00);
        `CHK("out2 set", 8'h01, s2)
        u_host.io(H_OUT2, 1'b0, 1'b0);
        `CHK("out2 read", 8'h00, s2)
        u_host.io(H_LW, 1'b0, 1'b0);
        `CHK("irq3", 1'b1, bi_full)
        rd(1'b1, 8'h80);
        sp(S_LR, 8'h00);
        `CHK("last rd", 8'h00, s3)
        sp(S_LW, 8'h00);
        `CHK("last wr", 8'h40, s3)
        u_host.io(H_LR, 1'b0, 1'b0);
        `CHK("host last rd", 8'h00, s3)
        sp(S_LW, 8'h00);
        sp(S_S3, 8'hff);
        `CHK("ones wr", 8'h40, s3)
        sp(S_S3, 8'h00);
        `CHK("out full zero", 8'h00, s3)
        u_host.io(H_FW, 1'b0, 1'b0);
        sp(S_FW, 8'h00);
        `CHK("host mode", 8'h20, s3)
        sp(S_LR, 8'h00);
        `CHK("host mode off", 8'h00, s3)
        sp(S_FW, 8'h00);
        u_host.io(H_FW, 1'b0, 1'b0);
        `CHK("slave mode", 8'h10, s3)
        u_host.io(H_LR, 1'b0, 1'b0);
        `CHK("slave mode off", 8'h00, s3)
        sp(S_FW, 8'h00);
        `CHK("slave mode on", 8'h10, s3)
        sp(S_S3, 8'h00);
        `CHK("slave mode zero", 8'h00, s3)
        fork
            u_host.io(H_FW, 1'b0, 1'b0);
            sp(S_FW, 8'h00);
        join
        `CHK("tie", 8'h20, s3)
        sp(S_LR, 8'h00);
        u_host.io(H_LW, 1'b0, 1'b0);
        // Walk all mode and select levels with a flag standing in bank 3.
        for (int i = 0; i < 4; i++)
        begin
            @(negedge sys_clk_i);
            {en, csel} = i[1:0];
            #1;
            `CHK("layout", i[1] | ~i[0], lay)
            `CHK("stat3 shown", (i[1] | ~i[0]) ? 8'h80 : 8'h00, s3)
        end
        // Reset again in mid-run, with user bits, a flag and read data
        // all standing, so that the reset really has something to clear.
        sp(S_S2, 8'hff);
        @(negedge sys_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        `CHK("stat2 rerst", 8'h00, s2)
        `CHK("stat3 rerst", 8'h00, s3)
        `CHK("rdata rerst", 8'h00, rdata)
        `CHK("rvalid rerst", 1'b0, rvalid)
        final_report();
    end

endmodule

`default_nettype wire
